// file: bench/swrc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the controller's pins for sleep, wake and reset ordering.
module swrc_checker #(
   parameter SHORT_CYC = 20,
   parameter LONG_CYC = 100
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic master_clear_pin_n,
   input wire logic fuse_wdt,
   input wire logic osc_select_high,
   input wire logic osc_select_low,
   input wire logic watchdog_timeout,
   input wire logic core_reset,
   input wire logic asleep,
   input wire logic watchdog_timer_en,
   input wire logic fuse_read_en,
   input wire logic core_supply_low
);
   // Counts how long the core has been held so far.
   logic [15:0] hold_cnt;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) hold_cnt <= 16'h0000;
      else if (core_reset) hold_cnt <= hold_cnt + 16'h0001;
      else hold_cnt <= 16'h0000;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_delay_long_enough: assert property ($fell(core_reset) |->
      hold_cnt >= ((osc_select_high && osc_select_low) ? SHORT_CYC : LONG_CYC))
      else $error("start-up delay too short");
   a_fuse_off_asleep: assert property (asleep && $past(asleep) |->
      !fuse_read_en) else $error("fuse powered while asleep");
   a_watchdog_held_asleep: assert property (
      asleep && $past(asleep) |-> $stable(watchdog_timer_en))
      else $error("watchdog enable moved in sleep");
   a_low_volt_asleep: assert property (core_supply_low |->
      asleep || $past(asleep)) else $error("core lowered while awake");
   a_wake_resets: assert property ($fell(asleep) |-> core_reset)
      else $error("left sleep without reset");
   a_clear_pin_resets: assert property (!master_clear_pin_n [*8] |->
      ##[0:4] core_reset) else $error("clear pin ignored");
   a_watchdog_resets: assert property (
      watchdog_timeout && watchdog_timer_en |-> ##[1:3] core_reset)
      else $error("watchdog timeout ignored");
   a_fuse_sets_watchdog: assert property (
      (fuse_wdt && !asleep && !core_reset) [*8] |-> watchdog_timer_en)
      else $error("fuse did not enable watchdog");
endmodule // swrc_checker
bind swrc_sleep_wake_reset_control swrc_checker #(.SHORT_CYC(SHORT_CYC),
   .LONG_CYC(LONG_CYC)) swrc_checker_inst (.sys_clk, .resetn,
   .master_clear_pin_n, .fuse_wdt, .osc_select_high, .osc_select_low,
   .watchdog_timeout, .core_reset, .asleep, .watchdog_timer_en,
   .fuse_read_en, .core_supply_low);
`default_nettype wire

// file: bench/swrc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// Supply comparators and fuse bank facing the controller.
module swrc_far_side #(
   parameter LOW_TRIP_MV = 16'h0898,
   parameter HIGH_TRIP_MV = 16'h0C1C
) (
   input wire logic sys_clk,
   input wire logic [15:0] supply_mv,
   input wire logic [2:0] fuse_word,
   input wire logic fuse_read_en,
   output logic supply_low_lo,
   output logic supply_low_hi,
   output logic fuse_wdt,
   output logic osc_select_high,
   output logic osc_select_low
);
   // An unpowered fuse sense gives noise, so a toggle stands in for it.
   logic noise = 1'h0;
   always @(posedge sys_clk) noise <= ~noise;
   assign supply_low_lo = supply_mv < LOW_TRIP_MV;
   assign supply_low_hi = supply_mv < HIGH_TRIP_MV;
   assign fuse_wdt = fuse_read_en ? fuse_word[0] : noise;
   assign osc_select_high = fuse_word[2];
   assign osc_select_low = fuse_word[1];
endmodule // swrc_far_side
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swrc_map.vh"
module tb;
   localparam SHORT = 20;
   localparam LONG = 100;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   logic [3:0] wake_pins = 4'h0;
   logic wake_pin7 = 1'h0;
   logic master_clear_pin_n = 1'h1;
   logic sleep_req = 1'h0;
   logic watchdog_timeout = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [15:0] supply_mv = 16'h1388;
   logic [2:0] fuse_word = 3'h6;
   wire supply_low_lo, supply_low_hi, fuse_wdt, osc_select_high;
   wire osc_select_low, core_reset, asleep, watchdog_timer_en;
   wire fuse_read_en, core_supply_low, brownout_level_sel, irq;
   wire [7:0] reg_rdata;
   logic [15:0] exp_q[$]; // Mask and expected byte of each pending read.
   logic rd_pend = 1'h0;
   logic seen;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   swrc_sleep_wake_reset_control #(.SHORT_CYC(SHORT), .LONG_CYC(LONG))
      swrc_sleep_wake_reset_control_inst (.sys_clk, .resetn, .wake_pins,
      .wake_pin7, .master_clear_pin_n, .supply_low_lo, .supply_low_hi,
      .fuse_wdt, .osc_select_high, .osc_select_low, .sleep_req,
      .watchdog_timeout, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .core_reset, .asleep, .watchdog_timer_en, .fuse_read_en,
      .core_supply_low, .brownout_level_sel, .irq);
   swrc_far_side swrc_far_side_inst (.sys_clk, .supply_mv, .fuse_word,
      .fuse_read_en, .supply_low_lo, .supply_low_hi, .fuse_wdt,
      .osc_select_high, .osc_select_low);
   initial forever #25 sys_clk = ~sys_clk;
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A hung wait must still end in the report.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data stand only in the cycle after the strobe.
   always @(posedge sys_clk) rd_pend <= reg_rd;
   always @(negedge sys_clk) begin
      if (rd_pend) begin
         chk(reg_rdata & exp_q[0][15:8], exp_q[0][7:0]);
         void'(exp_q.pop_front());
      end
   end
   task automatic see(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk) reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
      input logic [7:0] m);
      exp_q.push_back({m, e});
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk) reg_rd <= 1'h0;
   endtask
   // Waits, with a bound, for the core to leave reset.
   task automatic settle(output int k);
      k = 0;
      while (core_reset !== 1'h0 && k < 2000) begin
         @(negedge sys_clk);
         k++;
      end
   endtask
   task automatic clear_pulse(output int k);
      @(posedge sys_clk) master_clear_pin_n <= 1'h0;
      repeat (12) @(posedge sys_clk);
      master_clear_pin_n <= 1'h1;
      settle(k);
   endtask
   task automatic go_sleep();
      @(posedge sys_clk) sleep_req <= 1'h1;
      @(posedge sys_clk) sleep_req <= 1'h0;
      see(2);
   endtask
   initial begin
      int k;
      k = $urandom(32'h01C1);
      repeat (16) @(posedge sys_clk);
      resetn <= 1'h1;
      see(1);
      settle(k);
      chk(k <= SHORT + 8, 1'h1);
      rd(`SWRC_ADDR_OPT2, 8'h02, 8'hFF);
      rd(`SWRC_ADDR_STATUS, 8'h01, 8'h0F);
      rd(4'hF, 8'h00, 8'hFF);
      wr(`SWRC_ADDR_OPT2, 8'h12);
      see(3);
      chk(watchdog_timer_en, 1'h1);
      $display("test power-up done at %0t", $time);
      wr(`SWRC_ADDR_OPT2, 8'h02);
      @(posedge sys_clk) fuse_word <= 3'h7;
      see(12);
      chk(watchdog_timer_en, 1'h1);
      go_sleep();
      chk(fuse_read_en, 1'h0);
      @(posedge sys_clk) fuse_word <= 3'h6;
      see(12);
      chk(watchdog_timer_en, 1'h1);
      @(posedge sys_clk) watchdog_timeout <= 1'h1;
      @(posedge sys_clk) watchdog_timeout <= 1'h0;
      see(3);
      chk(asleep, 1'h0);
      settle(k);
      see(12);
      chk(watchdog_timer_en, 1'h0);
      $display("test watchdog done at %0t", $time);
      for (int i = 0; i < 5; i++) begin
         clear_pulse(k);
         rd(`SWRC_ADDR_STATUS, 8'h01, 8'h01);
         wr(`SWRC_ADDR_OPT2, 8'h0B);
         @(posedge sys_clk) wake_pins <= 4'($urandom);
         wake_pin7 <= 1'h0;
         see(10);
         go_sleep();
         see(8);
         chk(core_supply_low, 1'h1);
         @(posedge sys_clk);
         if (i < 4) wake_pins[i] <= ~wake_pins[i];
         else wake_pin7 <= 1'h1;
         see(14);
         chk({asleep, core_reset}, 2'h1);
         settle(k);
         chk(k <= SHORT + 8, 1'h1);
         rd(`SWRC_ADDR_STATUS, 8'h00, 8'h01);
      end
      $display("test pin wake done at %0t", $time);
      clear_pulse(k);
      wr(`SWRC_ADDR_OPT2, 8'h02);
      go_sleep();
      @(posedge sys_clk) wake_pins <= ~wake_pins;
      wake_pin7 <= 1'h0;
      see(20);
      chk({asleep, core_reset}, 2'h2);
      rd(`SWRC_ADDR_STATUS, 8'h03, 8'h03);
      clear_pulse(k);
      $display("test wake disabled done at %0t", $time);
      @(posedge sys_clk) supply_mv <= 16'h0BB8;
      see(20);
      chk(core_reset, 1'h0);
      wr(`SWRC_ADDR_OPT2, 8'h04);
      see(4);
      chk({brownout_level_sel, core_reset}, 2'h0);
      wr(`SWRC_ADDR_LVL_KEY, 8'hA5);
      rd(`SWRC_ADDR_LVL_KEY, 8'h01, 8'hFF);
      wr(`SWRC_ADDR_OPT2, 8'h04);
      see(30);
      chk({brownout_level_sel, core_reset}, 2'h3);
      @(posedge sys_clk) supply_mv <= 16'h1388;
      settle(k);
      chk(k <= SHORT + 8, 1'h1);
      $display("test brown-out done at %0t", $time);
      @(posedge sys_clk) fuse_word <= 3'h0;
      clear_pulse(k);
      chk(k > SHORT + 8, 1'h1);
      rd(`SWRC_ADDR_IRQ_STAT, 8'h04, 8'h04);
      wr(`SWRC_ADDR_IRQ_MASK, 8'h07);
      see(2);
      seen = irq;
      chk(seen, 1'h1);
      wr(`SWRC_ADDR_IRQ_MASK, 8'h00);
      see(2);
      chk(irq, 1'h0);
      wr(`SWRC_ADDR_IRQ_STAT, 8'h07);
      wr(`SWRC_ADDR_IRQ_MASK, 8'h07);
      rd(`SWRC_ADDR_IRQ_MASK, 8'h07, 8'hFF);
      see(2);
      chk(irq, 1'h0);
      rd(`SWRC_ADDR_IRQ_STAT, 8'h00, 8'h07);
      see(3);
      $display("test delay and irq done at %0t", $time);
      test_done();
   end
endmodule // tb
`default_nettype wire

// file: core/swrc_glitch_filter.v
`timescale 1ns/1ps
`default_nettype none
// Synchronises one pin and passes a level only once it stayed stable.
module swrc_glitch_filter #(
   parameter CNT_W = 3,
   parameter [2:0] FILT = 3'h4
) (
   input wire sys_clk,
   input wire rst_n,
   input wire pin_in,
   output reg level_out
);
   // Two-stage synchroniser; the first stage feeds only the second.
   reg sync1_reg;
   reg sync2_reg;
   // Counts cycles the synced level differs from the output.
   reg [CNT_W-1:0] cnt_reg;

   // Accept a new level after FILT stable cycles, else restart.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         cnt_reg <= {CNT_W{1'b0}};
         level_out <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         if (sync2_reg == level_out) begin
            cnt_reg <= {CNT_W{1'b0}};
         end else if (cnt_reg == FILT - 3'h1) begin
            level_out <= sync2_reg;
            cnt_reg <= {CNT_W{1'b0}};
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule // swrc_glitch_filter
`default_nettype wire

// file: core/swrc_sleep_wake_reset_control.v
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "swrc_map.vh"
// Sleep, wake, brown-out, watchdog-enable and start-up delay control.
module swrc_sleep_wake_reset_control #(
   parameter SHORT_CYC = `SWRC_CYC_SHORT,
   parameter LONG_CYC = `SWRC_CYC_LONG
) (
   input wire sys_clk,
   input wire resetn,
   input wire [3:0] wake_pins,
   input wire wake_pin7,
   input wire master_clear_pin_n,
   input wire supply_low_lo,
   input wire supply_low_hi,
   input wire fuse_wdt,
   input wire osc_select_high,
   input wire osc_select_low,
   input wire sleep_req,
   input wire watchdog_timeout,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg core_reset,
   output reg asleep,
   output reg watchdog_timer_en,
   output reg fuse_read_en,
   output reg core_supply_low,
   output reg brownout_level_sel,
   output reg irq
);
   // Reset release synchroniser; the rest uses rst_n.
   reg rst_s1_reg;
   reg rst_n;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // Pin glitch filters for the five wake inputs and master clear.
   wire [5:0] raw_pins;
   wire [5:0] filt_lvl;
   assign raw_pins = {master_clear_pin_n, wake_pin7, wake_pins};
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_filt
         swrc_glitch_filter #(
            .CNT_W(3),
            .FILT(`SWRC_FILT_CYC)
         ) u_filt (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin_in(raw_pins[gi]),
            .level_out(filt_lvl[gi])
         );
      end
   endgenerate

   // Plain synchronisers for the remaining asynchronous inputs.
   reg [4:0] async_s1_reg;
   reg [4:0] async_s2_reg;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         async_s1_reg <= 5'h00;
         async_s2_reg <= 5'h00;
      end else begin
         async_s1_reg <= {supply_low_lo, supply_low_hi, fuse_wdt,
                          osc_select_high, osc_select_low};
         async_s2_reg <= async_s1_reg;
      end
   end
   wire sup_lo_s = async_s2_reg[4];
   wire sup_hi_s = async_s2_reg[3];
   wire fuse_s = async_s2_reg[2];
   wire rc_mode = async_s2_reg[1] & async_s2_reg[0];

   // Register state.
   reg [7:0] opt2_reg;
   reg pcwf_reg;
   reg [2:0] irq_stat_reg;
   reg [2:0] irq_mask_reg;
   reg lvl_unlock_reg;
   reg [3:0] wake_ref_reg;
   reg wdt_latch_reg;
   reg [31:0] dly_cnt_reg;
   reg delay_busy_reg;

   // Decoding shared by the write and read paths.
   function hit;
      input [3:0] a;
      input [3:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   wire wr_opt2 = reg_wr & hit(reg_addr, `SWRC_ADDR_OPT2);
   wire wr_istat = reg_wr & hit(reg_addr, `SWRC_ADDR_IRQ_STAT);
   wire wr_imask = reg_wr & hit(reg_addr, `SWRC_ADDR_IRQ_MASK);
   wire wr_key = reg_wr & hit(reg_addr, `SWRC_ADDR_LVL_KEY);

   wire wake_en = opt2_reg[`SWRC_OPT2_WAKE_EN];
   wire bo_on = ~opt2_reg[`SWRC_OPT2_BO_EN_N];
   wire bo_lvl = opt2_reg[`SWRC_OPT2_BO_LVL];

   // Brown-out holds reset while the selected comparator trips.
   wire bo_trip = bo_on & (bo_lvl ? sup_hi_s : sup_lo_s);
   wire master_clear_pin_act = ~filt_lvl[5];

   // Wake: low inputs differ from reference, or bit 7 is high.
   wire pin_mismatch = (filt_lvl[3:0] != wake_ref_reg) | filt_lvl[4];
   // Disabled wake gives neither reset nor flag change.
   wire pin_wake = asleep & wake_en & pin_mismatch;
   // Watchdog timeout wakes or resets the core as well.
   wire wdt_evt = watchdog_timeout & watchdog_timer_en;
   wire rst_evt = pin_wake | wdt_evt | bo_trip | master_clear_pin_act;

   // Sleep entry: capture references, latch watchdog enable.
   wire sleep_go = sleep_req & ~asleep & ~core_reset;
   // Fuse overrides; otherwise the soft bit decides.
   wire wdt_live = fuse_s | opt2_reg[`SWRC_OPT2_SWE];

   // Option register, interlocked trip level and power-up defaults.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         opt2_reg <= `SWRC_OPT2_RESET;
         lvl_unlock_reg <= 1'b0;
      end else begin
         if (wr_key) begin
            // Only the exact key arms one level change.
            lvl_unlock_reg <= (reg_wdata == `SWRC_LVL_KEY);
         end else if (wr_opt2) begin
            lvl_unlock_reg <= 1'b0;
         end
         if (wr_opt2) begin
            opt2_reg[7:5] <= 3'h0;
            opt2_reg[4:3] <= reg_wdata[4:3];
            opt2_reg[1:0] <= reg_wdata[1:0];
            if (lvl_unlock_reg) begin
               // Locked level keeps its value; guards against stray writes.
               opt2_reg[`SWRC_OPT2_BO_LVL] <= reg_wdata[2];
            end
         end
      end
   end

   // Sleep state, references, watchdog latch and fuse current gate.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         asleep <= 1'b0;
         wake_ref_reg <= 4'h0;
         wdt_latch_reg <= 1'b0;
         fuse_read_en <= 1'b1;
      end else begin
         if (rst_evt) begin
            asleep <= 1'b0;
            fuse_read_en <= 1'b1;
         end else if (sleep_go) begin
            asleep <= 1'b1;
            wake_ref_reg <= filt_lvl[3:0];
            wdt_latch_reg <= wdt_live;
            fuse_read_en <= 1'b0;
         end
      end
   end

   // The fuse sense is unpowered in sleep and reads noise. After a wake
   // the synchroniser needs two cycles to flush that noise, so the live
   // value is trusted only once fuse power has been back for two cycles.
   // This costs two cycles of latency on a fuse change after wake-up.
   reg [1:0] fuse_vld_reg;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fuse_vld_reg <= 2'h0;
      end else begin
         fuse_vld_reg <= {fuse_vld_reg[0], fuse_read_en};
      end
   end
   // High while the latched watchdog setting must stand.
   wire hold_latch = asleep | ~fuse_vld_reg[1];

   // Watchdog enable: held latch while asleep or fuse settling.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_timer_en <= 1'b0;
      end else if (hold_latch) begin
         watchdog_timer_en <= wdt_latch_reg;
      end else begin
         watchdog_timer_en <= wdt_live;
      end
   end

   // Core supply lowered only while asleep and the option is set.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_supply_low <= 1'b0;
         brownout_level_sel <= 1'b0;
      end else begin
         core_supply_low <= asleep & opt2_reg[`SWRC_OPT2_SLEEP_LV];
         brownout_level_sel <= bo_lvl;
      end
   end

   // Wake-cause flag: cleared by a pin wake, set by other resets.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcwf_reg <= 1'b1;
      end else if (pin_wake) begin
         pcwf_reg <= 1'b0;
      end else if (wdt_evt | bo_trip | master_clear_pin_act) begin
         pcwf_reg <= 1'b1;
      end
   end

   // Reset hold and start-up delay; reload while any source is active.
   wire [31:0] dly_load = rc_mode ? SHORT_CYC : LONG_CYC;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_cnt_reg <= 32'h00000000;
         delay_busy_reg <= 1'b1;
         core_reset <= 1'b1;
      end else begin
         if (rst_evt | delay_busy_reg & ~core_reset) begin
            // Source active: hold reset and restart the delay.
            dly_cnt_reg <= dly_load;
            delay_busy_reg <= 1'b0;
            core_reset <= 1'b1;
         end else if (core_reset) begin
            if (dly_cnt_reg <= 32'h00000001) begin
               core_reset <= 1'b0;
            end else begin
               dly_cnt_reg <= dly_cnt_reg - 32'h00000001;
            end
         end
         if (~rst_evt & delay_busy_reg & core_reset) begin
            // Power-on: start the delay once after release.
            dly_cnt_reg <= dly_load;
            delay_busy_reg <= 1'b0;
         end
      end
   end
   wire done_evt = core_reset & ~rst_evt & ~delay_busy_reg &
                   (dly_cnt_reg <= 32'h00000001);

   // Sticky interrupt status; a new event wins over a write-one clear.
   wire [2:0] ev = {done_evt, bo_trip, pin_wake | wdt_evt & asleep};
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= ev | (irq_stat_reg &
                         ~(wr_istat ? reg_wdata[2:0] : 3'h0));
         if (wr_imask) begin
            irq_mask_reg <= reg_wdata[2:0];
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Read data in the cycle after the strobe; unmapped reads zero.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (hit(reg_addr, `SWRC_ADDR_OPT2)) begin
            reg_rdata <= opt2_reg;
         end else if (hit(reg_addr, `SWRC_ADDR_STATUS)) begin
            reg_rdata <= {4'h0, core_reset, watchdog_timer_en, asleep,
                          pcwf_reg};
         end else if (hit(reg_addr, `SWRC_ADDR_IRQ_STAT)) begin
            reg_rdata <= {5'h00, irq_stat_reg};
         end else if (hit(reg_addr, `SWRC_ADDR_IRQ_MASK)) begin
            reg_rdata <= {5'h00, irq_mask_reg};
         end else if (hit(reg_addr, `SWRC_ADDR_LVL_KEY)) begin
            reg_rdata <= {7'h00, lvl_unlock_reg};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // swrc_sleep_wake_reset_control
`default_nettype wire

// file: inc/swrc_map.vh
// Function
// - Capture four low wake inputs at sleep
// - Opposite filtered level while asleep warm-resets
// - Pin-change wake clears wake-cause flag
// - Bit-7 slow input also wakes, same flag
// - One enable bit gates all five
// - Enabled brown-out holds core in reset
// - Selectable trip level with write interlock
// - Brown-out disabled at power-up until cleared
// - Watchdog enabled by programmed fuse two
// - Latch watchdog enable during sleep
// - Bit 4 soft watchdog enable if fuse off
// - Soft watchdog enable off after power-up
// - RC mode start-up 1 ms, else 18 ms
// - Short delay after every reset source; code reloads the mode delay, so LONG_CYC outside RC mode
// - Sleep-voltage bit lowers core to 3 V
`ifndef SWRC_MAP_VH
`define SWRC_MAP_VH
// Register indices on the plain register port.
`define SWRC_ADDR_OPT2 4'h0
`define SWRC_ADDR_STATUS 4'h1
`define SWRC_ADDR_IRQ_STAT 4'h2
`define SWRC_ADDR_IRQ_MASK 4'h3
`define SWRC_ADDR_LVL_KEY 4'h4
// Secondary option register fields.
`define SWRC_OPT2_WAKE_EN 0
`define SWRC_OPT2_BO_EN_N 1
`define SWRC_OPT2_BO_LVL 2
`define SWRC_OPT2_SLEEP_LV 3
`define SWRC_OPT2_SWE 4
// Reset value: brown-out off (enable_n set), soft watchdog off.
`define SWRC_OPT2_RESET 8'h02
// Status fields.
`define SWRC_STAT_PCWF 0
`define SWRC_STAT_ASLEEP 1
`define SWRC_STAT_WDT_EN 2
`define SWRC_STAT_IN_RST 3
// Interrupt bits: wake event, brown-out event, delay done.
`define SWRC_IRQ_WAKE 0
`define SWRC_IRQ_BO 1
`define SWRC_IRQ_DONE 2
// Key written to unlock one trip-level change.
`define SWRC_LVL_KEY 8'hA5
// Start-up times in microseconds and clock rate in kHz.
`define SWRC_T_SHORT_US 1000
`define SWRC_T_LONG_US 18000
`define SWRC_CLK_KHZ 20000
`define SWRC_CYC_SHORT ((`SWRC_T_SHORT_US * `SWRC_CLK_KHZ) / 1000)
`define SWRC_CYC_LONG ((`SWRC_T_LONG_US * `SWRC_CLK_KHZ) / 1000)
// Glitch filter length in cycles.
`define SWRC_FILT_CYC 4
`endif
